//--- logic/bmf_pkg.sv
// Package of constants and types for the bus-matching FIFO control block
package bmf_pkg;
  localparam int BMF_WORD_W = 36;
  localparam int BMF_BYTE_W = 9;
  localparam int BMF_HALF_W = 18;
  localparam int BMF_DEPTH = 16;
  localparam int BMF_OFS_W = 32;
  // Parity bit positions in an offset word
  localparam int BMF_PAR_B0 = 8;
  localparam int BMF_PAR_B1 = 17;
  localparam int BMF_PAR_B2 = 26;
  localparam int BMF_PAR_B3 = 35;
  // Width codes: 0 = x36, 1 = x18, 2 = x9
  localparam logic [1:0] BMF_W36 = 2'h0;
  localparam logic [1:0] BMF_W18 = 2'h1;
  localparam logic [1:0] BMF_W9 = 2'h2;
  // Reset values of the latched widths and of the data registers
  localparam logic [1:0] BMF_WIDTH_RST = 2'h0;
  localparam logic [BMF_WORD_W-1:0] BMF_DATA_RST = 36'h0_0000_0000;
  typedef enum logic {BMF_BIG, BMF_LITTLE} bmf_order_t;
endpackage

//--- logic/bmf_fifo.sv
// Parameterised FIFO with valid/ready on both sides
`timescale 1ns/1ps
module bmf_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Mark and rewind of the drain pointer
  input wire logic mark,
  input wire logic rewind
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] mark_ptr;
  logic marked;
  logic push;
  logic pop;
  logic [AW:0] hold_ptr;

  // Words from the mark onward stay resident until the mark is cleared
  assign hold_ptr = marked ? mark_ptr : rd_ptr;
  assign in_ready = (wr_ptr - hold_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Rewind wins over a pop in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_ptr <= '0;
    end else if (clear) begin
      rd_ptr <= '0;
    end else if (rewind && marked) begin
      rd_ptr <= mark_ptr;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mark_ptr <= '0;
      marked <= 1'b0;
    end else if (clear) begin
      mark_ptr <= '0;
      marked <= 1'b0;
    end else if (mark) begin
      mark_ptr <= rd_ptr;
      marked <= 1'b1;
    end
  end
endmodule // bmf_fifo

//--- logic/bmf_ctrl.sv
// Bus-matching FIFO: configuration latch, width matching and read control
// Functional notes
// - Mark on a read clock edge records the location being read.
// - Retransmit going low after a mark rewinds the read pointer there.
// - Width-match, write and read width pins sampled at master reset.
// - Big-endian: most significant part of a long word read first.
// - Little-endian: least significant byte of a long word read first.
// - Byte-order pin latched at master reset; low big, high little.
// - Interspersed parity: bits 8, 17, 26, 35 are parity in offset words.
// - Non-interspersed: bits 8, 17, 26 valid, bits 32 to 35 ignored.
// - Parity placement pin low at reset non-interspersed, high interspersed.
// - Idle device powers down; any operation wakes it at once.
// - Read chip select sampled on read clock; inactive floats outputs.
// - Output enable and read chip select together gate output buffer.
// - Read timing select latched at reset; high clocked, low strobed.
// - Write timing select latched at reset; high clocked, low strobed.
// - Flag shows empty in standard mode, output valid in fall-through.
// - Fall-through or standard timing chosen at master reset.
// - Read clock echo only works with a clocked read port.
// - A test access port with a one-bit bypass path is provided.
`timescale 1ns/1ps
module bmf_ctrl
  import bmf_pkg::*;
#(
  parameter int DEPTH = BMF_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic master_reset_n,
  // Configuration straps
  input wire logic width_match_enable,
  input wire logic write_width_select,
  input wire logic read_width_select,
  input wire logic byte_order_select,
  input wire logic parity_placement_select,
  input wire logic read_port_sync_select,
  input wire logic write_port_sync_select,
  input wire logic fallthrough_or_serial_in,
  // Write port
  input wire logic write_en,
  input wire logic write_strobe,
  input wire logic [bmf_pkg::BMF_WORD_W-1:0] write_data_in,
  output logic write_ready,
  // Offset load path
  input wire logic offset_load,
  output logic [bmf_pkg::BMF_OFS_W-1:0] offset_value,
  // Read port
  input wire logic read_en,
  input wire logic read_strobe,
  input wire logic read_chip_select_n,
  input wire logic output_enable_n,
  input wire logic mark,
  input wire logic retransmit_n,
  output logic [bmf_pkg::BMF_WORD_W-1:0] read_data_out,
  output logic [bmf_pkg::BMF_WORD_W-1:0] read_data_oe_n,
  output logic empty_or_valid_flag_n,
  output logic read_clock_echo,
  // Status
  output logic power_down,
  output logic [1:0] write_width,
  output logic [1:0] read_width,
  // Test access port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo
);
  import bmf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers (three flops, second and third must agree)
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1, s2, s3;
  logic [NSYNC-1:0] pin_q;
  assign pin_raw = {master_reset_n, write_strobe, read_strobe, mark,
                    retransmit_n, read_chip_select_n, tck};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // Idle pin levels, so no false edge or mark follows reset
      s1 <= 7'h46;
      s2 <= 7'h46;
      s3 <= 7'h46;
      pin_q <= 7'h46;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < NSYNC; i++) begin
        if (s2[i] == s3[i]) begin
          pin_q[i] <= s3[i];
        end
      end
    end
  end
  logic mrs_n, wr_stb, rd_stb, mark_q, rt_n, rcs_n_q, tck_q;
  assign {mrs_n, wr_stb, rd_stb, mark_q, rt_n, rcs_n_q, tck_q} = pin_q;

  logic wr_stb_d, rd_stb_d, rt_n_d, tck_d;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_stb_d <= 1'b1;
      rd_stb_d <= 1'b1;
      rt_n_d <= 1'b1;
      tck_d <= 1'b0;
    end else begin
      wr_stb_d <= wr_stb;
      rd_stb_d <= rd_stb;
      rt_n_d <= rt_n;
      tck_d <= tck_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration latched while master reset is held
  logic in_mrs;
  logic sync_rd, sync_wr, fwft, parity_il;
  bmf_order_t order;
  assign in_mrs = !mrs_n;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      write_width <= BMF_WIDTH_RST;
      read_width <= BMF_WIDTH_RST;
    end else if (in_mrs) begin
      write_width <= BMF_W36;
      read_width <= BMF_W36;
      if (width_match_enable) begin
        unique case ({write_width_select, read_width_select})
          2'b00: read_width <= BMF_W18;
          2'b01: read_width <= BMF_W9;
          2'b10: write_width <= BMF_W18;
          2'b11: write_width <= BMF_W9;
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      order <= BMF_BIG;
      parity_il <= 1'b0;
      sync_rd <= 1'b1;
      sync_wr <= 1'b1;
      fwft <= 1'b0;
    end else if (in_mrs) begin
      order <= byte_order_select ? BMF_LITTLE : BMF_BIG;
      parity_il <= parity_placement_select;
      sync_rd <= read_port_sync_select;
      sync_wr <= write_port_sync_select;
      fwft <= fallthrough_or_serial_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write and read strobes in either timing mode
  logic wr_op, rd_op;
  assign wr_op = mrs_n && (sync_wr ? write_en : (wr_stb && !wr_stb_d));
  assign rd_op = mrs_n && (sync_rd ? read_en : (rd_stb && !rd_stb_d));

  ////////////////////////////////////////////////////////////////////////
  // Write side packing of narrow words
  logic [BMF_WORD_W-1:0] pack;
  logic [1:0] pack_cnt;
  logic [1:0] pack_last;
  logic pack_valid;
  logic fifo_in_ready;
  logic [BMF_BYTE_W-1:0] wbyte;
  logic [BMF_HALF_W-1:0] whalf;
  assign pack_last = (write_width == BMF_W9) ? 2'h3 :
                     (write_width == BMF_W18) ? 2'h1 : 2'h0;
  assign write_ready = fifo_in_ready && !pack_valid;
  assign wbyte = write_data_in[BMF_BYTE_W-1:0];
  assign whalf = write_data_in[BMF_HALF_W-1:0];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pack <= BMF_DATA_RST;
      pack_cnt <= 2'h0;
      pack_valid <= 1'b0;
    end else if (in_mrs) begin
      pack_cnt <= 2'h0;
      pack_valid <= 1'b0;
    end else begin
      if (pack_valid && fifo_in_ready) begin
        pack_valid <= 1'b0;
      end
      if (wr_op && write_ready && !offset_load) begin
        if (write_width == BMF_W36) begin
          pack <= write_data_in;
        end else if (order == BMF_BIG) begin
          pack <= (write_width == BMF_W9) ?
            {pack[BMF_WORD_W-BMF_BYTE_W-1:0], wbyte} :
            {pack[BMF_HALF_W-1:0], whalf};
        end else begin
          pack <= (write_width == BMF_W9) ?
            {wbyte, pack[BMF_WORD_W-1:BMF_BYTE_W]} :
            {whalf, pack[BMF_WORD_W-1:BMF_HALF_W]};
        end
        pack_cnt <= (pack_cnt == pack_last) ? 2'h0 : pack_cnt + 2'h1;
        pack_valid <= pack_cnt == pack_last;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Offset word decode by parity placement
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      offset_value <= '0;
    end else if (wr_op && offset_load && mrs_n) begin
      if (parity_il) begin
        offset_value <= {write_data_in[34:27], write_data_in[25:18],
                         write_data_in[16:9], write_data_in[7:0]};
      end else begin
        offset_value <= write_data_in[BMF_OFS_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage
  logic fifo_valid, fifo_pop;
  logic [BMF_WORD_W-1:0] fifo_data;
  logic rewind;
  assign rewind = !rt_n && rt_n_d;
  bmf_fifo #(.WIDTH(BMF_WORD_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(in_mrs),
    .in_valid(pack_valid),
    .in_ready(fifo_in_ready),
    .in_data(pack),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .mark(mark_q && (sync_rd ? 1'b1 : rd_op) && mrs_n),
    .rewind(rewind && mrs_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read side: slice each long word, fall-through or standard
  logic [1:0] slice_cnt;
  logic [1:0] slice_last;
  logic [1:0] slice_sel;
  logic out_has;
  logic take;
  logic [BMF_WORD_W-1:0] next_q;
  assign slice_last = (read_width == BMF_W9) ? 2'h3 :
                      (read_width == BMF_W18) ? 2'h1 : 2'h0;
  assign slice_sel = (order == BMF_BIG) ? slice_last - slice_cnt : slice_cnt;
  assign take = fifo_valid && (rd_op || (fwft && !out_has)) && !rewind;
  assign fifo_pop = take && slice_cnt == slice_last;
  always_comb begin
    next_q = '0;
    unique case (read_width)
      BMF_W9: next_q[BMF_BYTE_W-1:0] =
        fifo_data[slice_sel*BMF_BYTE_W +: BMF_BYTE_W];
      BMF_W18: next_q[BMF_HALF_W-1:0] =
        fifo_data[slice_sel[0]*BMF_HALF_W +: BMF_HALF_W];
      default: next_q = fifo_data;
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_data_out <= BMF_DATA_RST;
      slice_cnt <= 2'h0;
      out_has <= 1'b0;
    end else if (in_mrs) begin
      read_data_out <= BMF_DATA_RST;
      slice_cnt <= 2'h0;
      out_has <= 1'b0;
    end else begin
      if (rewind) begin
        slice_cnt <= 2'h0;
      end
      if (take) begin
        read_data_out <= next_q;
        slice_cnt <= (slice_cnt == slice_last) ? 2'h0 : slice_cnt + 2'h1;
        out_has <= 1'b1;
      end else if (rd_op) begin
        out_has <= 1'b0;
      end
    end
  end
  // Fall-through: low when output holds data; standard: low when the FIFO holds data
  assign empty_or_valid_flag_n = fwft ? !out_has : !fifo_valid;

  ////////////////////////////////////////////////////////////////////////
  // Output buffer control
  logic rcs_active;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rcs_active <= 1'b0;
    end else begin
      rcs_active <= !rcs_n_q && mrs_n;
    end
  end
  assign read_data_oe_n = {BMF_WORD_W{output_enable_n || !rcs_active}};

  // Echo toggles per clock only in clocked read mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_clock_echo <= 1'b0;
    end else begin
      read_clock_echo <= sync_rd ? !read_clock_echo : 1'b0;
    end
  end

  // Idle detect
  assign power_down = !(wr_op || rd_op || take || pack_valid || in_mrs
                        || mark_q || rewind);

  ////////////////////////////////////////////////////////////////////////
  // Test access: bypass path shifted on sampled test clock edges
  logic [3:0] tap_state;
  logic bypass;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tap_state <= 4'h0;
      bypass <= 1'b0;
      tdo <= 1'b0;
    end else if (tck_q && !tck_d) begin
      tap_state <= tms ? 4'h0 : 4'h1;
      bypass <= tdi;
      tdo <= (tap_state == 4'h1) ? bypass : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence rt_fall_s;
    !rt_n && rt_n_d && mrs_n;
  endsequence
  cfg_width_a: assert property (@(posedge ref_clk) disable iff (rst)
    in_mrs && !width_match_enable |=> write_width == BMF_W36
      && read_width == BMF_W36) else $error("width latch wrong");
  cfg_order_a: assert property (@(posedge ref_clk) disable iff (rst)
    in_mrs |=> (order == BMF_LITTLE) == $past(byte_order_select))
    else $error("order latch wrong");
  par_il_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_op && offset_load && parity_il |=>
      offset_value[7:0] == $past(write_data_in[7:0])
      && offset_value[15:8] == $past(write_data_in[16:9]))
    else $error("parity strip wrong");
  par_nil_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_op && offset_load && !parity_il && mrs_n |=>
      offset_value == $past(write_data_in[31:0]))
    else $error("offset word wrong");
  oe_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    output_enable_n |-> read_data_oe_n[0])
    else $error("output not floated");
  rcs_float_a: assert property (@(posedge ref_clk) disable iff (rst)
    rcs_n_q ##1 rcs_n_q |-> read_data_oe_n[0])
    else $error("chip select ignored");
  flag_std_a: assert property (@(posedge ref_clk) disable iff (rst)
    !fwft && !in_mrs && pack_valid && fifo_in_ready |=>
      !empty_or_valid_flag_n)
    else $error("empty flag wrong");
  echo_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !sync_rd ##1 !sync_rd |-> !read_clock_echo)
    else $error("echo active");
  rewind_a: assert property (@(posedge ref_clk) disable iff (rst)
    rt_fall_s |=> slice_cnt == 2'h0) else $error("rewind lost");
  idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_op |-> !power_down) else $error("woke late");
endmodule // bmf_ctrl

//--- test/bmf_writer.sv
// Writer model standing on the write port of the FIFO control block
`timescale 1ns/1ps
module bmf_writer
  import bmf_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Port mode
  input wire logic clocked,
  input wire logic [1:0] width,
  // Write port
  input wire logic write_ready,
  output logic write_en,
  output logic write_strobe,
  output logic [bmf_pkg::BMF_WORD_W-1:0] write_data_in
);
  import bmf_pkg::*;
  logic [BMF_WORD_W-1:0] data_now;
  initial begin
    write_en = 1'b0;
    write_strobe = 1'b0;
    write_data_in = 36'h0_0000_0000;
  end
  task automatic push(input logic [BMF_WORD_W-1:0] d, output bit ok);
    int n;
    logic [BMF_WORD_W-1:0] keep;
    keep = 36'hF_FFFF_FFFF;
    // Unused upper lines held low on a narrow port
    if (width == BMF_W18) keep = 36'h0_0003_FFFF;
    if (width == BMF_W9) keep = 36'h0_0000_01FF;
    data_now = d & keep;
    n = 0;
    @(negedge ref_clk);
    write_data_in = data_now;
    if (clocked) begin
      write_en = 1'b1;
      #1;
      while (n < 200 && write_ready !== 1'b1) begin
        @(negedge ref_clk);
        #1;
        n++;
      end
      @(negedge ref_clk);
      write_en = 1'b0;
    end else begin
      // Strobe kept slower than a quarter of the clock
      repeat (4) @(negedge ref_clk);
      write_strobe = 1'b1;
      repeat (4) @(negedge ref_clk);
      write_strobe = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
    ok = (n < 200);
    write_data_in = ~data_now & keep;
  endtask
endmodule // bmf_writer

//--- test/test_bus_matching_fifo_config.sv
// Testbench for the bus-matching FIFO control block
`timescale 1ns/1ps
module test_bus_matching_fifo_config;
  import bmf_pkg::*;
  logic ref_clk, rst, master_reset_n;
  logic width_match_enable, write_width_select, read_width_select;
  logic byte_order_select, parity_placement_select;
  logic read_port_sync_select, write_port_sync_select;
  logic fallthrough_or_serial_in;
  logic write_en, write_strobe, write_ready, offset_load;
  logic [35:0] write_data_in, read_data_out, read_data_oe_n;
  logic [31:0] offset_value;
  logic read_en, read_strobe, read_chip_select_n, output_enable_n;
  logic mark, retransmit_n, empty_or_valid_flag_n, read_clock_echo;
  logic power_down, tck, tms, tdi, tdo, e;
  logic [1:0] write_width, read_width;
  logic [35:0] w;
  logic [7:0] wt_strap [5] = '{8'h06, 8'h86, 8'hA6, 8'hC6, 8'hE6};
  logic [3:0] wt_exp [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  logic [7:0] en_strap [4] = '{8'h86, 8'h96, 8'hA6, 8'hB6};
  int err_total = 0;
  int samples_checked = 0;
  int n;

  bmf_ctrl i_dut (.ref_clk(ref_clk), .rst(rst),
    .master_reset_n(master_reset_n),
    .width_match_enable(width_match_enable),
    .write_width_select(write_width_select),
    .read_width_select(read_width_select),
    .byte_order_select(byte_order_select),
    .parity_placement_select(parity_placement_select),
    .read_port_sync_select(read_port_sync_select),
    .write_port_sync_select(write_port_sync_select),
    .fallthrough_or_serial_in(fallthrough_or_serial_in),
    .write_en(write_en), .write_strobe(write_strobe),
    .write_data_in(write_data_in), .write_ready(write_ready),
    .offset_load(offset_load), .offset_value(offset_value),
    .read_en(read_en), .read_strobe(read_strobe),
    .read_chip_select_n(read_chip_select_n),
    .output_enable_n(output_enable_n), .mark(mark),
    .retransmit_n(retransmit_n), .read_data_out(read_data_out),
    .read_data_oe_n(read_data_oe_n),
    .empty_or_valid_flag_n(empty_or_valid_flag_n),
    .read_clock_echo(read_clock_echo), .power_down(power_down),
    .write_width(write_width), .read_width(read_width),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  bmf_writer i_writer (.ref_clk(ref_clk),
    .clocked(write_port_sync_select), .width(write_width),
    .write_ready(write_ready), .write_en(write_en),
    .write_strobe(write_strobe), .write_data_in(write_data_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Straps, msb first: match, wr width, rd width, order, parity,
  // rd clocked, wr clocked, fall-through
  task automatic strap(input logic [7:0] s);
    @(negedge ref_clk);
    {width_match_enable, write_width_select, read_width_select,
     byte_order_select, parity_placement_select, read_port_sync_select,
     write_port_sync_select, fallthrough_or_serial_in} = s;
    master_reset_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    master_reset_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [35:0] d);
    bit ok;
    i_writer.push(d, ok);
    check({35'h0, ok}, 36'h1);
    if (!ok) summarize();
  endtask

  task automatic rd(input logic [35:0] exp);
    @(negedge ref_clk);
    read_en = 1'b1;
    @(negedge ref_clk);
    read_en = 1'b0;
    check(read_data_out, exp);
  endtask

  task automatic wait_for(input bit flag, input logic [35:0] exp);
    logic [35:0] v;
    for (int k = 0; k < 20; k++) begin
      @(negedge ref_clk);
      v = flag ? {35'h0, empty_or_valid_flag_n} : read_data_oe_n;
      if (v === exp) break;
    end
    check(v, exp);
    if (v !== exp) summarize();
  endtask

  initial begin
    rst = 1'b1;
    master_reset_n = 1'b1;
    {width_match_enable, write_width_select, read_width_select,
     byte_order_select, parity_placement_select, read_port_sync_select,
     write_port_sync_select, fallthrough_or_serial_in} = 8'h06;
    {offset_load, read_en, read_strobe, mark, tck, tms, tdi} = '0;
    {read_chip_select_n, output_enable_n, retransmit_n} = 3'h7;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      strap(wt_strap[i]);
      check({32'h0, write_width, read_width}, {32'h0, wt_exp[i]});
    end
    $display("test widths done");
    strap(8'h06);
    check({35'h0, power_down}, 36'h1);
    check({35'h0, empty_or_valid_flag_n}, 36'h1);
    e = read_clock_echo;
    @(negedge ref_clk);
    check({35'h0, read_clock_echo}, {35'h0, ~e});
    check(read_data_oe_n, 36'hF_FFFF_FFFF);
    wr(36'h9_8765_4321);
    wait_for(1, 36'h0);
    {read_chip_select_n, output_enable_n} = 2'h0;
    wait_for(0, 36'h0);
    @(negedge ref_clk);
    read_en = 1'b1;
    #1;
    check({35'h0, power_down}, 36'h0);
    @(negedge ref_clk);
    read_en = 1'b0;
    check(read_data_out, 36'h9_8765_4321);
    wait_for(1, 36'h1);
    read_chip_select_n = 1'b1;
    wait_for(0, 36'hF_FFFF_FFFF);
    {read_chip_select_n, output_enable_n} = 2'h0;
    wait_for(0, 36'h0);
    output_enable_n = 1'b1;
    #1;
    check(read_data_oe_n, 36'hF_FFFF_FFFF);
    @(negedge ref_clk);
    output_enable_n = 1'b0;
    $display("test flags and outputs done");
    for (int i = 0; i < 16; i++) wr(36'(i) * 36'h1_0010_0101);
    @(negedge ref_clk);
    check({35'h0, write_ready}, 36'h0);
    for (int i = 0; i < 16; i++) rd(36'(i) * 36'h1_0010_0101);
    wait_for(1, 36'h1);
    $display("test fill and drain done");
    strap(8'h06);
    for (int i = 0; i < 3; i++) wr(36'hA_0000_0000 + 36'(i));
    rd(36'hA_0000_0000);
    mark = 1'b1;
    repeat (6) @(negedge ref_clk);
    mark = 1'b0;
    repeat (6) @(negedge ref_clk);
    rd(36'hA_0000_0001);
    rd(36'hA_0000_0002);
    retransmit_n = 1'b0;
    repeat (6) @(negedge ref_clk);
    retransmit_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    rd(36'hA_0000_0001);
    rd(36'hA_0000_0002);
    $display("test retransmit done");
    w = 36'h1_2345_6789;
    for (int m = 0; m < 4; m++) begin
      strap(en_strap[m]);
      wr(w);
      n = (m < 2) ? 2 : 4;
      for (int k = 0; k < n; k++) begin
        rd((w >> (((m % 2) ? k : n - 1 - k) * (36 / n)))
           & ((36'h1 << (36 / n)) - 36'h1));
      end
    end
    for (int m = 0; m < 2; m++) begin
      strap(m ? 8'hD6 : 8'hC6);
      wr(36'h0_0002_3456);
      wr(36'h0_0001_789A);
      rd(m ? 36'h5_E26A_3456 : 36'h8_D159_789A);
    end
    $display("test byte order done");
    for (int m = 0; m < 2; m++) begin
      strap(m ? 8'h0E : 8'h06);
      offset_load = 1'b1;
      wr(36'hF_0402_0101);
      offset_load = 1'b0;
      @(negedge ref_clk);
      check({4'h0, offset_value},
            m ? 36'h0_E000_0001 : 36'h0_0402_0101);
    end
    $display("test parity done");
    strap(8'h00);
    e = read_clock_echo;
    @(negedge ref_clk);
    check({34'h0, e, read_clock_echo}, 36'h0);
    wr(36'h5_A5A5_0F0F);
    repeat (2) @(negedge ref_clk);
    read_strobe = 1'b1;
    repeat (4) @(negedge ref_clk);
    read_strobe = 1'b0;
    repeat (4) @(negedge ref_clk);
    check(read_data_out, 36'h5_A5A5_0F0F);
    $display("test strobed ports done");
    strap(8'h07);
    wr(36'h3_C3C3_3C3C);
    wait_for(1, 36'h0);
    check(read_data_out, 36'h3_C3C3_3C3C);
    $display("test fall-through done");
    for (int m = 0; m < 2; m++) begin
      tdi = ~m[0];
      repeat (4) begin
        tck = 1'b1;
        repeat (2) @(negedge ref_clk);
        tck = 1'b0;
        repeat (2) @(negedge ref_clk);
      end
      repeat (4) @(negedge ref_clk);
      check({35'h0, tdo}, {35'h0, ~m[0]});
    end
    $display("test scan port done");
    summarize();
  end
endmodule // test_bus_matching_fifo_config
